// >>> design/sfd_decoder.sv
// Serial flash instruction decoder and lane framer
`timescale 1ns/100ps
`default_nettype none
module sfd_decoder import sfd_pkg::*; #(
  // Identity values are arbitrary
  parameter logic [7:0] MFR_ID = 8'h5A,
  parameter logic [7:0] DEV_ID = 8'hA5,
  parameter logic [7:0] MEM_TYPE = 8'h3C,
  parameter logic [7:0] CAPACITY = 8'h11,
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Link pins
  input wire logic SPI_CLK,
  input wire logic SPI_CS_N,
  input wire logic [3:0] LANE_IN,
  output logic [3:0] LANE_OUT,
  output logic [3:0] LANE_OE,
  // Status and array side
  input wire logic [7:0] STATUS_LOW_BYTE,
  input wire logic [7:0] STATUS_HIGH_BYTE,
  input wire logic OP_DONE,
  input wire logic [7:0] RD_DATA,
  output logic [23:0] RD_ADDR,
  output logic WRITE_ENABLE_LATCH,
  output logic POWER_DOWN,
  output logic OVERRUN,
  // Event stream
  output logic EVT_VALID,
  output sfd_evt_t EVT_DATA,
  input wire logic EVT_READY
);
  function automatic sfd_attr_t op_decode(input logic [7:0] op, input logic qe);
    sfd_attr_t a;
    a = '0;
    a.known = 1'b1;
    case (op)
      OP_RDSR1, OP_RDSR2: begin
        a.dout = 1'b1;
        a.busy_ok = 1'b1;
      end
      OP_WRSR: begin
        a.wr = 1'b1;
        a.din = 1'b1;
      end
      OP_PP, OP_QPP: begin
        a.known = (op == OP_PP) || qe;
        a.wr = 1'b1;
        a.adr = 1'b1;
        a.din = 1'b1;
        a.dw = (op == OP_QPP) ? LW_4 : LW_1;
      end
      OP_BE64, OP_BE32, OP_SE: begin
        a.wr = 1'b1;
        a.adr = 1'b1;
      end
      OP_CE1, OP_CE2: a.wr = 1'b1;
      OP_WREN, OP_WRDI, OP_PD, OP_ESUS, OP_ERES, OP_CRMR: a.known = 1'b1;
      OP_HPM: a.dummy = DUMMY_3B;
      OP_RPD: begin
        a.dummy = DUMMY_3B;
        a.dout = 1'b1;
      end
      OP_UID: begin
        a.dummy = DUMMY_4B;
        a.dout = 1'b1;
      end
      OP_MID, OP_READ: begin
        a.adr = 1'b1;
        a.dout = 1'b1;
      end
      OP_JID: a.dout = 1'b1;
      OP_FREAD, OP_DOR, OP_QOR: begin
        a.known = (op != OP_QOR) || qe;
        a.adr = 1'b1;
        a.dummy = DUMMY_FAST;
        a.dout = 1'b1;
        a.dw = (op == OP_DOR) ? LW_2 : (op == OP_QOR) ? LW_4 : LW_1;
      end
      OP_DIO: begin
        a.adr = 1'b1;
        a.aw = LW_2;
        a.mode = 1'b1;
        a.dw = LW_2;
        a.dout = 1'b1;
      end
      OP_QIO, OP_OWQ: begin
        a.known = qe;
        a.adr = 1'b1;
        a.aw = LW_4;
        a.mode = 1'b1;
        a.dummy = (op == OP_QIO) ? DUMMY_QIO : 6'h00;
        a.dw = LW_4;
        a.dout = 1'b1;
      end
      default: a.known = 1'b0;
    endcase
    return a;
  endfunction

  function automatic sfd_phase_t ph_after(input sfd_phase_t p, input sfd_attr_t a);
    sfd_phase_t n;
    n = PH_SKIP;
    if (p == PH_OPC && a.adr) n = PH_ADDR;
    else if ((p == PH_OPC || p == PH_ADDR) && a.mode) n = PH_MODE;
    else if (p != PH_DUMMY && a.dummy != 6'h00) n = PH_DUMMY;
    else if (a.din) n = PH_DIN;
    else if (a.dout) n = PH_DOUT;
    return n;
  endfunction

  function automatic logic [5:0] ph_len(input sfd_phase_t p, input sfd_attr_t a);
    case (p)
      PH_ADDR: return ADDR_CLKS >> a.aw;
      PH_MODE: return BYTE_CLKS >> a.aw;
      PH_DUMMY: return a.dummy;
      PH_DIN, PH_DOUT: return BYTE_CLKS >> a.dw;
      default: return BYTE_CLKS;
    endcase
  endfunction

  logic [5:0] s1_ff, s2_ff;
  logic sck_s3_ff, cs_s3_ff;
  logic sck, cs_n, rise, fall, cs_fall, cs_rise;
  logic [3:0] lane;
  sfd_phase_t phase_ff, nph;
  sfd_attr_t attr_ff, nattr;
  logic [5:0] left_ff, ocnt_ff;
  logic [31:0] sr_ff, shifted;
  logic [7:0] op_ff, cont_op_ff, byte_sel, src, sr_out_ff;
  logic [1:0] lw, nbytes_ff;
  logic last, gate, aligned_ff, hdr_ff, ign_ff, cont_ff;
  logic wel_ff, pd_ff, ovr_ff, frame_ok, data_ok, wel_set;
  logic [3:0] out_ff, oe_ff;
  logic [23:0] rd_addr_ff;
  logic [2:0] bidx_ff;
  logic ev_go, pend_v_ff, buf_ready;
  sfd_evt_t ev, pend_ff;

  // Pin synchronisers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
      sck_s3_ff <= 1'b0;
      cs_s3_ff <= 1'b1;
    end else begin
      s1_ff <= {SPI_CLK, SPI_CS_N, LANE_IN};
      s2_ff <= s1_ff;
      sck_s3_ff <= s2_ff[5];
      cs_s3_ff <= s2_ff[4];
    end
  end

  always_comb begin
    sck = s2_ff[5];
    cs_n = s2_ff[4];
    lane = s2_ff[3:0];
    rise = sck & ~sck_s3_ff & ~cs_n;
    fall = ~sck & sck_s3_ff & ~cs_n;
    cs_fall = ~cs_n & cs_s3_ff;
    cs_rise = cs_n & ~cs_s3_ff;
    lw = (phase_ff == PH_ADDR || phase_ff == PH_MODE) ? attr_ff.aw :
         (phase_ff == PH_DIN) ? attr_ff.dw : LW_1;
    case (lw)
      LW_2: shifted = {sr_ff[29:0], lane[1:0]};
      LW_4: shifted = {sr_ff[27:0], lane[3:0]};
      default: shifted = {sr_ff[30:0], lane[0]};
    endcase
    last = rise && left_ff == 6'h01;
    nattr = (phase_ff == PH_OPC) ? op_decode(shifted[7:0], STATUS_HIGH_BYTE[1]) : attr_ff;
    gate = !nattr.known || (STATUS_LOW_BYTE[0] && !nattr.busy_ok) ||
           (pd_ff && shifted[7:0] != OP_RPD);
    if (phase_ff == PH_OPC) nph = gate ? PH_SKIP : ph_after(PH_OPC, nattr);
    else if (phase_ff == PH_DIN || phase_ff == PH_DOUT || phase_ff == PH_SKIP) nph = phase_ff;
    else nph = ph_after(phase_ff, attr_ff);
  end

  // Frame sequencing on rising link edges
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_ff <= PH_OPC;
      attr_ff <= '0;
      left_ff <= BYTE_CLKS;
      sr_ff <= '0;
      op_ff <= 8'h00;
      cont_op_ff <= 8'h00;
      cont_ff <= 1'b0;
      aligned_ff <= 1'b0;
      hdr_ff <= 1'b0;
      ign_ff <= 1'b0;
      nbytes_ff <= 2'h0;
    end else if (cs_fall) begin
      aligned_ff <= 1'b0;
      hdr_ff <= 1'b0;
      ign_ff <= 1'b0;
      nbytes_ff <= 2'h0;
      if (cont_ff) begin
        op_ff <= cont_op_ff;
        attr_ff <= op_decode(cont_op_ff, STATUS_HIGH_BYTE[1]);
        phase_ff <= PH_ADDR;
        left_ff <= ph_len(PH_ADDR, op_decode(cont_op_ff, STATUS_HIGH_BYTE[1]));
      end else begin
        phase_ff <= PH_OPC;
        left_ff <= BYTE_CLKS;
      end
    end else if (rise) begin
      sr_ff <= shifted;
      aligned_ff <= last;
      if (last) begin
        phase_ff <= nph;
        left_ff <= ph_len(nph, nattr);
        attr_ff <= nattr;
        if (phase_ff == PH_OPC) begin
          op_ff <= shifted[7:0];
          ign_ff <= gate;
        end
        if (phase_ff == PH_MODE) begin
          cont_ff <= shifted[5:4] == CONT_KEY;
          cont_op_ff <= op_ff;
        end
        if (nph == PH_DIN || nph == PH_DOUT || nph == PH_SKIP) hdr_ff <= 1'b1;
        if ((phase_ff == PH_DIN || phase_ff == PH_SKIP) && nbytes_ff != 2'h3)
          nbytes_ff <= nbytes_ff + 2'h1;
      end else begin
        left_ff <= left_ff - 6'h01;
      end
    end
  end

  // Instruction completion checks at select rise
  always_comb begin
    frame_ok = cs_rise && aligned_ff && hdr_ff && !ign_ff;
    case (op_ff)
      OP_WRSR: data_ok = nbytes_ff == 2'h1 || nbytes_ff == 2'h2;
      OP_PP, OP_QPP: data_ok = nbytes_ff != 2'h0;
      default: data_ok = nbytes_ff == 2'h0;
    endcase
    wel_set = frame_ok && data_ok && op_ff == OP_WREN;
  end

  // Write enable latch and power-down state
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wel_ff <= WEL_RST;
      pd_ff <= 1'b0;
    end else begin
      if (wel_set) wel_ff <= 1'b1;
      else if (OP_DONE) wel_ff <= 1'b0;
      else if (frame_ok && data_ok && op_ff == OP_WRDI) wel_ff <= 1'b0;
      if (frame_ok && data_ok && op_ff == OP_PD) pd_ff <= 1'b1;
      else if (last && phase_ff == PH_OPC && shifted[7:0] == OP_RPD) pd_ff <= 1'b0;
    end
  end

  // Event words towards the program and erase engines
  always_comb begin
    ev_go = 1'b0;
    ev = '{kind: EV_HDR, op: op_ff, addr: rd_addr_ff, data: sr_ff[7:0]};
    if (last && !gate && nattr.wr && (nph == PH_DIN || nph == PH_SKIP)) begin
      ev_go = 1'b1;
      ev.op = (phase_ff == PH_OPC) ? shifted[7:0] : op_ff;
      ev.addr = (phase_ff == PH_ADDR) ? shifted[23:0] : 24'h000000;
    end else if (last && phase_ff == PH_DIN && !ign_ff) begin
      ev_go = 1'b1;
      ev.kind = EV_DATA;
      ev.data = shifted[7:0];
    end else if (cs_rise && hdr_ff && !ign_ff && attr_ff.wr) begin
      ev_go = 1'b1;
      ev.kind = (frame_ok && data_ok && wel_ff) ? EV_COMMIT : EV_ABORT;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_ff <= '0;
      pend_v_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else if (ev_go) begin
      if (pend_v_ff && !buf_ready) ovr_ff <= 1'b1;
      pend_ff <= ev;
      pend_v_ff <= 1'b1;
    end else if (buf_ready) begin
      pend_v_ff <= 1'b0;
    end
  end

  sfd_buf #(.WIDTH($bits(sfd_evt_t)), .DEPTH(2)) u_buf (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .in_valid(pend_v_ff),
    .in_data(pend_ff),
    .in_ready(buf_ready),
    .out_valid(EVT_VALID),
    .out_data(EVT_DATA),
    .out_ready(EVT_READY)
  );

  // Byte returned to the host
  always_comb begin
    case (op_ff)
      OP_RDSR1: byte_sel = {STATUS_LOW_BYTE[7:2], wel_ff, STATUS_LOW_BYTE[0]};
      OP_RDSR2: byte_sel = STATUS_HIGH_BYTE;
      OP_RPD: byte_sel = DEV_ID;
      OP_MID: byte_sel = (bidx_ff[0] ^ rd_addr_ff[0]) ? DEV_ID : MFR_ID;
      OP_JID: byte_sel = (bidx_ff == 3'h0) ? MFR_ID : (bidx_ff == 3'h1) ? MEM_TYPE : CAPACITY;
      OP_UID: byte_sel = UNIQUE_ID[8*(3'h7-bidx_ff) +: 8];
      default: byte_sel = RD_DATA;
    endcase
    src = (ocnt_ff == 6'h00) ? byte_sel : sr_out_ff;
  end

  // Lane drive on falling link edges
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_ff <= 4'h0;
      oe_ff <= 4'h0;
      sr_out_ff <= 8'h00;
      ocnt_ff <= 6'h00;
      bidx_ff <= 3'h0;
      rd_addr_ff <= 24'h000000;
    end else if (cs_n) begin
      oe_ff <= 4'h0;
      out_ff <= 4'h0;
      ocnt_ff <= 6'h00;
      bidx_ff <= 3'h0;
    end else begin
      if (last && phase_ff == PH_ADDR) rd_addr_ff <= shifted[23:0];
      if (fall && phase_ff == PH_DOUT) begin
        case (attr_ff.dw)
          LW_4: begin
            out_ff <= src[7:4];
            oe_ff <= 4'hF;
            sr_out_ff <= {src[3:0], 4'h0};
          end
          LW_2: begin
            out_ff <= {2'h0, src[7:6]};
            oe_ff <= 4'h3;
            sr_out_ff <= {src[5:0], 2'h0};
          end
          default: begin
            out_ff <= {2'h0, src[7], 1'b0};
            oe_ff <= 4'h2;
            sr_out_ff <= {src[6:0], 1'b0};
          end
        endcase
        ocnt_ff <= (ocnt_ff + 6'h01 == (BYTE_CLKS >> attr_ff.dw)) ? 6'h00 : ocnt_ff + 6'h01;
        if (ocnt_ff == 6'h00) begin
          bidx_ff <= (op_ff == OP_JID && bidx_ff == 3'h2) ? 3'h0 : bidx_ff + 3'h1;
          if (attr_ff.adr && op_ff != OP_MID) rd_addr_ff <= rd_addr_ff + 24'h000001;
        end
      end
    end
  end

  assign LANE_OUT = out_ff;
  assign LANE_OE = oe_ff;
  assign RD_ADDR = rd_addr_ff;
  assign WRITE_ENABLE_LATCH = wel_ff;
  assign POWER_DOWN = pd_ff;
  assign OVERRUN = ovr_ff;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_wel_set;
    wel_set |=> wel_ff ##1 (wel_ff || $past(OP_DONE));
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");
  property p_wel_clr;
    frame_ok && data_ok && op_ff == OP_WRDI |=> !wel_ff;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");
  property p_wel_done;
    OP_DONE && !wel_set |=> !wel_ff;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept after done");
  property p_busy_ign;
    last && phase_ff == PH_OPC && STATUS_LOW_BYTE[0] && shifted[7:0] != OP_RDSR1 &&
      shifted[7:0] != OP_RDSR2 |=> phase_ff == PH_SKIP && ign_ff;
  endproperty
  a_busy_ign: assert property (p_busy_ign) else $error("busy opcode taken");
  property p_unaligned;
    cs_rise && !aligned_ff && hdr_ff && !ign_ff && attr_ff.wr |=> pend_ff.kind == EV_ABORT;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("partial byte committed");
  property p_fast_dummy;
    last && phase_ff == PH_ADDR && op_ff == OP_FREAD |=> phase_ff == PH_DUMMY && left_ff == 6'h08;
  endproperty
  a_fast_dummy: assert property (p_fast_dummy) else $error("fast read dummy wrong");
  property p_qio_dummy;
    last && phase_ff == PH_MODE && op_ff == OP_QIO |=> phase_ff == PH_DUMMY && left_ff == 6'h04
      ##1 (LANE_OE == 4'h0) [*3];
  endproperty
  a_qio_dummy: assert property (p_qio_dummy) else $error("quad dummy wrong");
  property p_quad_nib;
    fall && phase_ff == PH_DOUT && attr_ff.dw == LW_4 && ocnt_ff == 6'h00 |=>
      LANE_OUT == $past(byte_sel[7:4]) && LANE_OE == 4'hF;
  endproperty
  a_quad_nib: assert property (p_quad_nib) else $error("upper nibble not first");
  property p_single_out;
    fall && phase_ff == PH_DOUT && attr_ff.dw == LW_1 |=> LANE_OE == 4'h2;
  endproperty
  a_single_out: assert property (p_single_out) else $error("single output lane wrong");
  property p_opcode_first;
    cs_fall && !cont_ff |=> phase_ff == PH_OPC && left_ff == BYTE_CLKS;
  endproperty
  a_opcode_first: assert property (p_opcode_first) else $error("frame not at opcode");
  property p_idle_off;
    cs_n |=> LANE_OE == 4'h0;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("lanes driven while idle");

  c_wel: cover property (wel_set);
  c_commit: cover property (ev_go && ev.kind == EV_COMMIT);
  c_qio: cover property (fall && phase_ff == PH_DOUT && op_ff == OP_QIO);
  c_status: cover property (fall && phase_ff == PH_DOUT && op_ff == OP_RDSR1 && bidx_ff == 3'h2);
endmodule // sfd_decoder
`default_nettype wire

// >>> design/sfd_pkg.sv
// Constants and types shared by the serial flash command decoder
// Notes on behaviour
// - A complete one-byte write-enable instruction sets the write enable latch.
// - A complete one-byte write-disable instruction clears the write enable latch.
// - Latch clears at reset and when any program, erase or status write completes.
// - Enable and disable: select low, one opcode byte on rising edges, select high.
// - Bytes travel most significant bit first; returned bytes go out on the output line.
// - Status reads resend the chosen status byte until select rises.
// - Identification read repeats its id byte after three dummy bytes until select rises.
// - Quad data bytes travel as two nibbles, upper nibble first, lane 3 highest.
// - Dual output sends a byte in four clocks, lane 1 odd bits, lane 0 even.
// - Quad I/O fast read lets four undriven clocks pass before the first nibble.
// - Select falling starts an instruction; the first byte in is the opcode, or the address after a continuous-read mode byte.
// - Write, program or erase without a whole number of bytes has no effect.
// - While busy, every opcode except status read is ignored, but a release opcode still ends power-down and continuous-read frames still run.
// - Single, dual and quad output fast reads wait eight dummy clocks after the address.
package sfd_pkg;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_CE1 = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_ESUS = 8'h75;
  localparam logic [7:0] OP_ERES = 8'h7A;
  localparam logic [7:0] OP_PD = 8'hB9;
  localparam logic [7:0] OP_HPM = 8'hA3;
  localparam logic [7:0] OP_CRMR = 8'hFF;
  localparam logic [7:0] OP_RPD = 8'hAB;
  localparam logic [7:0] OP_MID = 8'h90;
  localparam logic [7:0] OP_UID = 8'h4B;
  localparam logic [7:0] OP_JID = 8'h9F;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_OWQ = 8'hE3;
  // Lane width codes, log2 of lanes used
  localparam logic [1:0] LW_1 = 2'h0;
  localparam logic [1:0] LW_2 = 2'h1;
  localparam logic [1:0] LW_4 = 2'h2;
  // Clock counts of fields, then continuous-read key and reset values
  localparam logic [5:0] BYTE_CLKS = 6'h08;
  localparam logic [5:0] ADDR_CLKS = 6'h18;
  localparam logic [5:0] DUMMY_FAST = 6'h08;
  localparam logic [5:0] DUMMY_QIO = 6'h04;
  localparam logic [5:0] DUMMY_3B = 6'h18;
  localparam logic [5:0] DUMMY_4B = 6'h20;
  localparam logic [1:0] CONT_KEY = 2'h2;
  localparam logic WEL_RST = 1'b0;
  localparam logic [5:0] SYNC_RST = 6'h10;

  typedef enum logic [2:0] {
    PH_OPC = 3'b000,
    PH_ADDR = 3'b001,
    PH_MODE = 3'b010,
    PH_DUMMY = 3'b011,
    PH_DIN = 3'b100,
    PH_DOUT = 3'b101,
    PH_SKIP = 3'b110
  } sfd_phase_t;

  typedef enum logic [1:0] {
    EV_HDR = 2'b00,
    EV_DATA = 2'b01,
    EV_COMMIT = 2'b10,
    EV_ABORT = 2'b11
  } sfd_evk_t;

  typedef struct packed {
    logic known;
    logic adr;
    logic [1:0] aw;
    logic mode;
    logic [5:0] dummy;
    logic [1:0] dw;
    logic din;
    logic dout;
    logic wr;
    logic busy_ok;
  } sfd_attr_t;

  typedef struct packed {
    sfd_evk_t kind;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] data;
  } sfd_evt_t;
endpackage

// >>> design/sfd_buf.sv
// Small shifting buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sfd_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] up_w [DEPTH];
  logic [DEPTH-1:0] full_ff;
  logic [DEPTH-1:0] vs;
  logic [DEPTH-1:0] prev;
  logic pop;
  logic push;

  assign in_ready = !full_ff[DEPTH-1];
  assign pop = full_ff[0] & out_ready;
  assign push = in_valid & in_ready;
  assign vs = pop ? (full_ff >> 1) : full_ff;
  assign prev = {vs[DEPTH-2:0], 1'b1};
  assign out_valid = full_ff[0];
  assign out_data = mem_ff[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    if (i < DEPTH - 1) begin : g_up
      assign up_w[i] = mem_ff[i+1];
    end else begin : g_top
      assign up_w[i] = mem_ff[i];
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_ff[i] <= '0;
        full_ff[i] <= 1'b0;
      end else if (push && !vs[i] && prev[i]) begin
        mem_ff[i] <= in_data;
        full_ff[i] <= 1'b1;
      end else begin
        if (pop) begin
          mem_ff[i] <= up_w[i];
        end
        full_ff[i] <= vs[i];
      end
    end
  end
endmodule // sfd_buf
`default_nettype wire

// >>> verification/sfd_host_model.sv
// Behavioural SPI host that drives select, serial clock and lanes
`timescale 1ns/100ps
`default_nettype none
module sfd_host_model (
  // Core clock used for pacing
  input wire logic clk,
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic [3:0] lanes,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    lanes = 4'hA;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Frame opens with select falling, clock held low
  task automatic start();
    tick(1);
    cs_n <= 1'b0;
    tick(4);
  endtask
  // Frame closes; released lanes show the inverse of their last value
  task automatic stop();
    sclk <= 1'b0;
    tick(4);
    cs_n <= 1'b1;
    lanes <= ~lanes;
    tick(12);
  endtask
  // Single lane, most significant bit first, 320 ns clock period
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      sclk <= 1'b0;
      lanes[0] <= tx[i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      rx[i] = lane_out[1] ^ ~lane_oe[1];
    end
  endtask
  // One byte on w lanes per clock, highest bits first; released lanes read inverted
  task automatic xferw(input logic [7:0] tx, input int w, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i -= w) begin
      sclk <= 1'b0;
      if (w == 4) lanes <= tx[i -: 4];
      else if (w == 2) lanes[1:0] <= tx[i -: 2];
      else lanes[0] <= tx[i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      if (w == 4) rx[i -: 4] = lane_out ^ ~lane_oe;
      else if (w == 2) rx[i -: 2] = lane_out[1:0] ^ ~lane_oe[1:0];
      else rx[i] = lane_out[1] ^ ~lane_oe[1];
    end
  endtask
endmodule // sfd_host_model
`default_nettype wire

// >>> verification/serial_flash_command_decoder_tb_top.sv
// Self-checking bench for the serial flash command decoder
`timescale 1ns/100ps
`default_nettype none
module serial_flash_command_decoder_tb_top import sfd_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, op_done, evt_ready, write_enable_latch, pd, ovr, evt_valid;
  logic [3:0] lanes, lane_out, lane_oe;
  logic [7:0] st_lo, st_hi, rd_data, rx;
  logic [23:0] rd_addr;
  sfd_evt_t evt;
  int errors = 0;
  int comparisons = 0;
  always #20 core_clk = ~core_clk;
  // Array model: byte at an address is its low address byte plus 3C
  assign rd_data = rd_addr[7:0] + 8'h3C;
  sfd_decoder i_sfd_decoder (.CORE_CLK(core_clk), .RST_N(rst_n), .SPI_CLK(sclk),
    .SPI_CS_N(cs_n), .LANE_IN(lanes), .LANE_OUT(lane_out), .LANE_OE(lane_oe),
    .STATUS_LOW_BYTE(st_lo), .STATUS_HIGH_BYTE(st_hi), .OP_DONE(op_done),
    .RD_DATA(rd_data), .RD_ADDR(rd_addr), .WRITE_ENABLE_LATCH(write_enable_latch), .POWER_DOWN(pd),
    .OVERRUN(ovr), .EVT_VALID(evt_valid), .EVT_DATA(evt), .EVT_READY(evt_ready));
  sfd_host_model i_sfd_host_model (.clk(core_clk), .sclk(sclk), .cs_n(cs_n),
    .lanes(lanes), .lane_out(lane_out), .lane_oe(lane_oe));
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd1(input logic [7:0] op);
    i_sfd_host_model.start();
    i_sfd_host_model.xfer(op, 8, rx);
    i_sfd_host_model.stop();
  endtask
  // Opcode then n bytes returned, each compared with exp
  task automatic rd(input logic [7:0] op, input int dum, input int n, input logic [7:0] exp);
    i_sfd_host_model.start();
    i_sfd_host_model.xfer(op, 8, rx);
    repeat (dum) i_sfd_host_model.xfer(8'h00, 8, rx);
    for (int i = 0; i < n; i++) begin
      i_sfd_host_model.xfer(8'h00, 8, rx);
      chk(rx, exp);
    end
    i_sfd_host_model.stop();
  endtask
  // Three address bytes, a mode byte and dum dummy bytes, then n data bytes, all on w lanes; cont skips the opcode
  task automatic wide(input logic [7:0] op, input bit cont, input int w, input logic [23:0] a,
      input logic [7:0] m, input int dum, input int n);
    i_sfd_host_model.start();
    if (!cont) i_sfd_host_model.xfer(op, 8, rx);
    for (int i = 2; i >= 0; i--) i_sfd_host_model.xferw(a[8*i +: 8], w, rx);
    i_sfd_host_model.xferw(m, w, rx);
    repeat (dum) i_sfd_host_model.xferw(8'h00, w, rx);
    for (int i = 0; i < n; i++) begin
      i_sfd_host_model.xferw(8'h00, w, rx);
      chk(rx, a[7:0] + 8'(i) + 8'h3C);
    end
    i_sfd_host_model.stop();
    chk(rd_addr, a + 24'(n) + 24'h000001);
  endtask
  task automatic pop(input sfd_evk_t k, input logic [7:0] op);
    int n;
    n = 0;
    while (evt_valid !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      results();
    end
    chk({evt.kind, evt.op}, {k, op});
    @(posedge core_clk);
    evt_ready <= 1'b1;
    @(posedge core_clk);
    evt_ready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_latch();
    chk({write_enable_latch, evt_valid}, 2'b00);
    cmd1(OP_WREN);
    chk(write_enable_latch, 1'b1);
    cmd1(OP_WRDI);
    chk(write_enable_latch, 1'b0);
  endtask
  task automatic t_status();
    rd(OP_RDSR1, 0, 3, 8'hA4);
    rd(OP_RDSR2, 0, 2, 8'h5B);
    rd(OP_RPD, 3, 2, 8'hA5);
  endtask
  task automatic t_erase();
    cmd1(OP_WREN);
    i_sfd_host_model.start();
    i_sfd_host_model.xfer(OP_SE, 8, rx);
    i_sfd_host_model.xfer(8'h12, 8, rx);
    i_sfd_host_model.xfer(8'h34, 8, rx);
    i_sfd_host_model.xfer(8'h56, 8, rx);
    i_sfd_host_model.stop();
    chk(evt.addr, 24'h123456);
    pop(EV_HDR, OP_SE);
    pop(EV_COMMIT, OP_SE);
    chk({ovr, write_enable_latch}, 2'b01);
    @(posedge core_clk);
    op_done <= 1'b1;
    @(posedge core_clk);
    op_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(write_enable_latch, 1'b0);
  endtask
  task automatic t_abort();
    cmd1(OP_WREN);
    i_sfd_host_model.start();
    i_sfd_host_model.xfer(OP_SE, 8, rx);
    repeat (3) i_sfd_host_model.xfer(8'hC3, 8, rx);
    i_sfd_host_model.xfer(8'h00, 3, rx);
    i_sfd_host_model.stop();
    pop(EV_HDR, OP_SE);
    pop(EV_ABORT, OP_SE);
    cmd1(OP_WRDI);
  endtask
  task automatic t_busy();
    st_lo <= 8'hA5;
    cmd1(OP_WREN);
    chk(write_enable_latch, 1'b0);
    rd(OP_RDSR1, 0, 2, 8'hA5);
    st_lo <= 8'hA6;
  endtask
  task automatic t_power();
    cmd1(OP_PD);
    chk(pd, 1'b1);
    cmd1(OP_WREN);
    chk(write_enable_latch, 1'b0);
    rd(OP_RPD, 3, 1, 8'hA5);
    chk(pd, 1'b0);
  endtask
  task automatic t_quad();
    wide(OP_QIO, 1'b0, 4, 24'h000210, 8'h20, 2, 2);
    wide(OP_QIO, 1'b1, 4, 24'h000330, 8'h20, 2, 1);
    i_sfd_host_model.start();
    repeat (4) i_sfd_host_model.xferw(OP_CRMR, 4, rx);
    i_sfd_host_model.stop();
    rd(OP_RDSR2, 0, 1, 8'h5B);
    wide(OP_OWQ, 1'b0, 4, 24'h000140, 8'h00, 0, 2);
  endtask
  task automatic t_dual();
    wide(OP_DIO, 1'b0, 2, 24'h000520, 8'h00, 0, 2);
  endtask
  task automatic t_fast();
    wide(OP_FREAD, 1'b0, 1, 24'h000460, 8'h00, 0, 2);
  endtask
  initial begin
    st_lo = 8'hA6;
    st_hi = 8'h5B;
    op_done = 1'b0;
    evt_ready = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_latch();
    t_power();
    t_status();
    t_erase();
    t_abort();
    t_quad();
    t_dual();
    t_fast();
    t_busy();
    results();
  end
endmodule // serial_flash_command_decoder_tb_top
`default_nettype wire
